// file: core/lcr_pkg.sv
// Shared constants and types for the per-channel line interface configuration registers
package lcr_pkg;

  // Channel replication and host port geometry
  localparam int NUM_CH = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CH_LSB = 4;
  localparam int CH_SEL_W = 4;
  localparam int OFF_W = 4;

  // Register offsets within one channel window
  localparam logic [OFF_W-1:0] OFF_JITTER = 4'h1;
  localparam logic [OFF_W-1:0] OFF_TEST_LOOP = 4'h2;
  localparam logic [OFF_W-1:0] OFF_CODING = 4'h3;

  // Reset values
  localparam logic [DATA_W-1:0] REG_RST = 8'h00;
  localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;

  // Jitter configuration register fields
  localparam int JPATH_LSB = 2;
  localparam int JPATH_W = 2;
  localparam int BW_BIT = 1;
  localparam int DEPTH_BIT = 0;

  // Test and loopback control register fields
  localparam int INV_BIT = 7;
  localparam int PAT_LSB = 4;
  localparam int PAT_W = 3;
  localparam int TRANSMITTER_POWER_BIT_BIT = 3;
  localparam int LOOP_LSB = 0;
  localparam int LOOP_W = 3;

  // Coding register fields
  localparam int CODING_BIT = 5;

  // Attenuator path select codes for jitter_path_select
  typedef enum logic [1:0] {
    JA_OFF = 2'h0,
    JA_TX = 2'h1,
    JA_RX = 2'h2,
    JA_RX_ALT = 2'h3
  } lcr_ja_path_t;

  // Test pattern and loopback select codes
  localparam logic [PAT_W-1:0] PAT_QRSS = 3'h4;
  localparam logic [PAT_W-1:0] PAT_ONES = 3'h5;
  localparam logic [LOOP_W-1:0] LOOP_DUAL = 3'h4;
  localparam logic [LOOP_W-1:0] LOOP_ANALOG = 3'h5;
  localparam logic [LOOP_W-1:0] LOOP_REMOTE = 3'h6;
  localparam logic [LOOP_W-1:0] LOOP_DIGITAL = 3'h7;

  // Attenuator FIFO depths in bits, latency is half the depth
  localparam int DEPTH_W = 7;
  localparam logic [DEPTH_W-1:0] FIFO_DEPTH_SHORT = 7'h20;
  localparam logic [DEPTH_W-1:0] FIFO_DEPTH_LONG = 7'h40;

  // Host port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } lcr_host_req_t;

  // Stored configuration of one channel
  typedef struct packed {
    logic [JPATH_W-1:0] jitter_path_select;
    logic attenuator_bandwidth_select;
    logic attenuator_buffer_depth;
    logic test_pattern_invert;
    logic [PAT_W-1:0] line_test_pattern;
    logic transmitter_power_bit;
    logic [LOOP_W-1:0] loop_select;
    logic line_coding_select;
  } lcr_chan_cfg_t;

  // Decoded controls of one channel for the datapath
  typedef struct packed {
    logic ja_tx_path;
    logic ja_rx_path;
    logic ja_bandwidth;
    logic [DEPTH_W-1:0] fifo_depth;
    logic [DEPTH_W-1:0] ja_latency;
    logic send_qrss;
    logic send_all_ones;
    logic qrss_invert;
    logic tx_powered;
    logic loop_dual;
    logic loop_analog;
    logic loop_remote;
    logic loop_digital;
    logic coding_ami;
  } lcr_chan_ctl_t;

endpackage

// file: core/lcr_chan_regs.sv
// Configuration register storage of one channel
`timescale 1ns/1ns
module lcr_chan_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [lcr_pkg::OFF_W-1:0] offset,
  input wire logic [lcr_pkg::DATA_W-1:0] wdata,
  output lcr_pkg::lcr_chan_cfg_t cfg
);

  logic [lcr_pkg::JPATH_W-1:0] jpath_q;
  logic bw_q;
  logic depth_q;
  logic inv_q;
  logic [lcr_pkg::PAT_W-1:0] pat_q;
  logic transmitter_power_bit_q;
  logic [lcr_pkg::LOOP_W-1:0] loop_q;
  logic coding_q;

  // Jitter configuration register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jpath_q <= lcr_pkg::JA_OFF;
      bw_q <= 1'b0;
      depth_q <= 1'b0;
    end else if (wr_en && offset == lcr_pkg::OFF_JITTER) begin
      jpath_q <= wdata[lcr_pkg::JPATH_LSB +: lcr_pkg::JPATH_W];
      bw_q <= wdata[lcr_pkg::BW_BIT];
      depth_q <= wdata[lcr_pkg::DEPTH_BIT];
    end
  end

  // Test pattern, transmitter power and loopback register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inv_q <= 1'b0;
      pat_q <= '0;
      transmitter_power_bit_q <= 1'b0;
      loop_q <= '0;
    end else if (wr_en && offset == lcr_pkg::OFF_TEST_LOOP) begin
      inv_q <= wdata[lcr_pkg::INV_BIT];
      pat_q <= wdata[lcr_pkg::PAT_LSB +: lcr_pkg::PAT_W];
      transmitter_power_bit_q <= wdata[lcr_pkg::TRANSMITTER_POWER_BIT_BIT];
      loop_q <= wdata[lcr_pkg::LOOP_LSB +: lcr_pkg::LOOP_W];
    end
  end

  // Coding register, bits other than bit 5 have no storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coding_q <= 1'b0;
    end else if (wr_en && offset == lcr_pkg::OFF_CODING) begin
      coding_q <= wdata[lcr_pkg::CODING_BIT];
    end
  end

  // Gather into the configuration struct
  assign cfg.jitter_path_select = jpath_q;
  assign cfg.attenuator_bandwidth_select = bw_q;
  assign cfg.attenuator_buffer_depth = depth_q;
  assign cfg.test_pattern_invert = inv_q;
  assign cfg.line_test_pattern = pat_q;
  assign cfg.transmitter_power_bit = transmitter_power_bit_q;
  assign cfg.loop_select = loop_q;
  assign cfg.line_coding_select = coding_q;

endmodule

// file: core/lcr_cfg_regs.sv
// Eight-channel line interface configuration register bank with decoded controls
`timescale 1ns/1ns
module lcr_cfg_regs #(
  parameter int NUM_CH = lcr_pkg::NUM_CH
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input lcr_pkg::lcr_host_req_t host_req,
  output logic [lcr_pkg::DATA_W-1:0] host_rdata,
  output logic host_rd_valid,
  input wire logic tx_power_pin_control,
  input wire logic [NUM_CH-1:0] tx_enable_pin,
  output lcr_pkg::lcr_chan_ctl_t [NUM_CH-1:0] chan_ctl
);

  logic rst_s1_q;
  logic rst_n;
  logic [NUM_CH-1:0] pin_s1_q;
  logic [NUM_CH-1:0] pin_s2_q;
  logic [NUM_CH-1:0] pin_s3_q;
  logic [NUM_CH-1:0] pin_filt_q;
  logic [lcr_pkg::CH_SEL_W-1:0] ch_sel;
  logic [lcr_pkg::OFF_W-1:0] off_sel;
  logic ch_hit;
  logic [lcr_pkg::DATA_W-1:0] rd_byte;
  logic [lcr_pkg::DATA_W-1:0] rdata_q;
  logic rd_valid_q;
  lcr_pkg::lcr_chan_cfg_t [NUM_CH-1:0] cfg;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Transmit-enable pins: three-flop synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= tx_enable_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Pin level accepted once second and third stages agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_filt_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_filt_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  // Address split into channel window and offset
  assign ch_sel = host_req.addr[lcr_pkg::CH_LSB +: lcr_pkg::CH_SEL_W];
  assign off_sel = host_req.addr[lcr_pkg::OFF_W-1:0];
  assign ch_hit = (32'(ch_sel) < NUM_CH);

  // Readback mux, unmapped addresses and unused bits read zero
  always_comb begin
    rd_byte = lcr_pkg::RD_IDLE;
    if (ch_hit) begin
      unique case (off_sel)
        lcr_pkg::OFF_JITTER: begin
          rd_byte[lcr_pkg::JPATH_LSB +: lcr_pkg::JPATH_W] = cfg[ch_sel].jitter_path_select;
          rd_byte[lcr_pkg::BW_BIT] = cfg[ch_sel].attenuator_bandwidth_select;
          rd_byte[lcr_pkg::DEPTH_BIT] = cfg[ch_sel].attenuator_buffer_depth;
        end
        lcr_pkg::OFF_TEST_LOOP: begin
          rd_byte[lcr_pkg::INV_BIT] = cfg[ch_sel].test_pattern_invert;
          rd_byte[lcr_pkg::PAT_LSB +: lcr_pkg::PAT_W] = cfg[ch_sel].line_test_pattern;
          rd_byte[lcr_pkg::TRANSMITTER_POWER_BIT_BIT] = cfg[ch_sel].transmitter_power_bit;
          rd_byte[lcr_pkg::LOOP_LSB +: lcr_pkg::LOOP_W] = cfg[ch_sel].loop_select;
        end
        lcr_pkg::OFF_CODING: begin
          rd_byte[lcr_pkg::CODING_BIT] = cfg[ch_sel].line_coding_select;
        end
        default: begin
          rd_byte = lcr_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // Read data registered, valid one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= lcr_pkg::RD_IDLE;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= host_req.rd;
      if (host_req.rd) begin
        rdata_q <= rd_byte;
      end
    end
  end

  assign host_rdata = rdata_q;
  assign host_rd_valid = rd_valid_q;

  // Read answer follows every strobe by one cycle, and only then
  sequence s_rd_strobe;
    host_req.rd;
  endsequence

  property p_rd_answer;
    @(posedge ref_clk) disable iff (!rst_n)
    s_rd_strobe |=> host_rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");

  property p_rd_quiet;
    @(posedge ref_clk) disable iff (!rst_n)
    !host_req.rd |=> !host_rd_valid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read answer without a strobe");

  property p_unmapped_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    (host_req.rd && !ch_hit) |=> host_rdata == lcr_pkg::RD_IDLE;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped channel read not zero");

  // Per-channel storage and decode
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam logic [lcr_pkg::CH_SEL_W-1:0] CH_ID = lcr_pkg::CH_SEL_W'(c);
    localparam logic [lcr_pkg::ADDR_W-1:0] A_JIT = {CH_ID, lcr_pkg::OFF_JITTER};
    localparam logic [lcr_pkg::ADDR_W-1:0] A_TLC = {CH_ID, lcr_pkg::OFF_TEST_LOOP};
    localparam logic [lcr_pkg::ADDR_W-1:0] A_COD = {CH_ID, lcr_pkg::OFF_CODING};
    lcr_pkg::lcr_chan_ctl_t ctl_d;
    lcr_pkg::lcr_chan_ctl_t ctl_q;
    logic ch_wr;

    // Channel window write enable
    assign ch_wr = host_req.wr && (ch_sel == CH_ID);

    lcr_chan_regs u_regs (
      .clk(ref_clk),
      .rst_n(rst_n),
      .wr_en(ch_wr),
      .offset(off_sel),
      .wdata(host_req.wdata),
      .cfg(cfg[c])
    );

    // Field decode into datapath controls
    always_comb begin
      ctl_d = '0;
      ctl_d.ja_tx_path = (cfg[c].jitter_path_select == lcr_pkg::JA_TX);
      ctl_d.ja_rx_path = cfg[c].jitter_path_select[1];
      ctl_d.ja_bandwidth = cfg[c].attenuator_bandwidth_select;
      ctl_d.fifo_depth = cfg[c].attenuator_buffer_depth ? lcr_pkg::FIFO_DEPTH_LONG
                                                        : lcr_pkg::FIFO_DEPTH_SHORT;
      ctl_d.ja_latency = ctl_d.fifo_depth >> 1;
      ctl_d.send_qrss = (cfg[c].line_test_pattern == lcr_pkg::PAT_QRSS);
      ctl_d.send_all_ones = (cfg[c].line_test_pattern == lcr_pkg::PAT_ONES);
      ctl_d.qrss_invert = cfg[c].test_pattern_invert;
      ctl_d.tx_powered = tx_power_pin_control ? pin_filt_q[c]
                                              : cfg[c].transmitter_power_bit;
      ctl_d.loop_dual = (cfg[c].loop_select == lcr_pkg::LOOP_DUAL);
      ctl_d.loop_analog = (cfg[c].loop_select == lcr_pkg::LOOP_ANALOG);
      ctl_d.loop_remote = (cfg[c].loop_select == lcr_pkg::LOOP_REMOTE);
      ctl_d.loop_digital = (cfg[c].loop_select == lcr_pkg::LOOP_DIGITAL);
      ctl_d.coding_ami = cfg[c].line_coding_select;
    end

    // Registered controls, all off after reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        ctl_q <= '0;
      end else begin
        ctl_q <= ctl_d;
      end
    end

    assign chan_ctl[c] = ctl_q;

    // Write of the test register followed by a read of the same address, and a read of the coding register
    sequence s_wr_tlc;
      host_req.wr && host_req.addr == A_TLC;
    endsequence

    sequence s_rd_same;
      host_req.rd && !host_req.wr && $stable(host_req.addr);
    endsequence

    sequence s_rd_cod;
      host_req.rd && !host_req.wr && host_req.addr == A_COD;
    endsequence

    property p_ja_path;
      @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> ctl_q.ja_tx_path == ($past(cfg[c].jitter_path_select) == 2'h1)
           && ctl_q.ja_rx_path == $past(cfg[c].jitter_path_select[1]);
    endproperty
    a_ja_path: assert property (p_ja_path) else $error("attenuator path decode wrong");

    property p_depth;
      @(posedge ref_clk) disable iff (!rst_n)
      (host_req.wr && host_req.addr == A_JIT) ##1 1'b1 |=>
        ctl_q.fifo_depth == ($past(host_req.wdata[0], 2) ? 7'h40 : 7'h20)
        && ctl_q.ja_latency == {1'b0, ctl_q.fifo_depth[6:1]};
    endproperty
    a_depth: assert property (p_depth) else $error("FIFO depth or latency wrong");

    property p_invert;
      @(posedge ref_clk) disable iff (!rst_n)
      s_wr_tlc ##1 1'b1 |=> ctl_q.qrss_invert == $past(host_req.wdata[7], 2);
    endproperty
    a_invert: assert property (p_invert) else $error("pattern invert not applied");

    property p_pattern;
      @(posedge ref_clk) disable iff (!rst_n)
      s_wr_tlc ##1 1'b1 |=>
        ctl_q.send_qrss == ($past(host_req.wdata[6:4], 2) == 3'h4)
        && ctl_q.send_all_ones == ($past(host_req.wdata[6:4], 2) == 3'h5);
    endproperty
    a_pattern: assert property (p_pattern) else $error("test pattern decode wrong");

    property p_reset_off;
      @(posedge ref_clk) disable iff (!resetn)
      $rose(rst_n) |-> !ctl_q.tx_powered [*3];
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("transmitter on after reset");

    property p_reg_power;
      @(posedge ref_clk) disable iff (!rst_n)
      (!tx_power_pin_control && !host_req.wr) ##1 !tx_power_pin_control |=>
        ctl_q.tx_powered == $past(cfg[c].transmitter_power_bit, 2);
    endproperty
    a_reg_power: assert property (p_reg_power) else $error("register power bit ignored");

    property p_pin_power;
      @(posedge ref_clk) disable iff (!rst_n)
      tx_power_pin_control |=> ctl_q.tx_powered == $past(pin_filt_q[c]);
    endproperty
    a_pin_power: assert property (p_pin_power) else $error("pin power control ignored");

    property p_loop;
      @(posedge ref_clk) disable iff (!rst_n)
      s_wr_tlc ##1 1'b1 |=>
        ctl_q.loop_digital == ($past(host_req.wdata[2:0], 2) == 3'h7)
        && ctl_q.loop_dual == ($past(host_req.wdata[2:0], 2) == 3'h4)
        && ctl_q.loop_remote == ($past(host_req.wdata[2:0], 2) == 3'h6)
        && ctl_q.loop_analog == ($past(host_req.wdata[2:0], 2) == 3'h5);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback decode wrong");

    property p_coding;
      @(posedge ref_clk) disable iff (!rst_n)
      (host_req.wr && host_req.addr == A_COD) ##1 1'b1 |=>
        ctl_q.coding_ami == $past(host_req.wdata[5], 2);
    endproperty
    a_coding: assert property (p_coding) else $error("coding select not applied");

    property p_unused_zero;
      @(posedge ref_clk) disable iff (!rst_n)
      s_rd_cod |=> host_rd_valid && host_rdata[7:6] == 2'h0 && host_rdata[4:0] == 5'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused coding bits not zero");

    property p_readback;
      @(posedge ref_clk) disable iff (!rst_n)
      s_wr_tlc ##1 s_rd_same |=> host_rd_valid && host_rdata == $past(host_req.wdata, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("channel register readback wrong");

    property p_bandwidth;
      @(posedge ref_clk) disable iff (!rst_n)
      (host_req.rd && host_req.addr == A_JIT) |=>
        host_rdata[1] == $past(cfg[c].attenuator_bandwidth_select);
    endproperty
    a_bandwidth: assert property (p_bandwidth) else $error("bandwidth select readback wrong");

    property p_pin_agree;
      @(posedge ref_clk) disable iff (!rst_n)
      (pin_s2_q[c] != pin_s3_q[c]) |=> $stable(pin_filt_q[c]);
    endproperty
    a_pin_agree: assert property (p_pin_agree) else $error("enable pin accepted before stages agree");

    property p_chan_isolated;
      @(posedge ref_clk) disable iff (!rst_n)
      (host_req.wr && ch_sel != CH_ID) |=> $stable(cfg[c]);
    endproperty
    a_chan_isolated: assert property (p_chan_isolated) else $error("write reached another channel");
  end

endmodule

// file: tb/liu_channel_config_regs_tb_top.sv
// Self-checking bench for the eight-channel configuration register bank
`timescale 1ns/1ns
module liu_channel_config_regs_tb_top;
  logic ref_clk;
  logic resetn;
  lcr_pkg::lcr_host_req_t host_req;
  logic [7:0] host_rdata;
  logic host_rd_valid;
  logic tx_power_pin_control;
  logic [7:0] tx_enable_pin;
  lcr_pkg::lcr_chan_ctl_t [7:0] chan_ctl;
  int fail_count;
  int checked;
  logic [7:0] sh_j [8];
  logic [7:0] sh_t [8];
  logic [7:0] sh_c [8];
  // Rows: address, write data, expected read back
  logic [23:0] rows [20] = '{24'h02_00_00, 24'h12_9A_9A, 24'h22_CB_CB, 24'h32_54_54, 24'h42_6D_6D,
    24'h52_76_76, 24'h62_CF_CF, 24'h72_38_38, 24'h01_F0_00, 24'h11_05_05, 24'h21_0A_0A, 24'h31_FF_0F,
    24'h71_03_03, 24'h03_FF_20, 24'h53_20_20, 24'h63_DF_00, 24'h04_FF_00, 24'h81_FF_00, 24'hF2_FF_00,
    24'h00_FF_00};

  lcr_cfg_regs #(
    .NUM_CH(8)
  ) i_dut (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .host_req(host_req),
    .host_rdata(host_rdata),
    .host_rd_valid(host_rd_valid),
    .tx_power_pin_control(tx_power_pin_control),
    .tx_enable_pin(tx_enable_pin),
    .chan_ctl(chan_ctl)
  );

  // Clock, 50 ns period
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One comparison with report
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
      fail_count++;
    end
  endtask

  // Expected decoded controls of one channel from the shadow registers
  function automatic lcr_pkg::lcr_chan_ctl_t exp_ctl(input int c);
    lcr_pkg::lcr_chan_ctl_t e;
    e.ja_tx_path = (sh_j[c][3:2] == 2'h1);
    e.ja_rx_path = sh_j[c][3];
    e.ja_bandwidth = sh_j[c][1];
    e.fifo_depth = sh_j[c][0] ? lcr_pkg::FIFO_DEPTH_LONG : lcr_pkg::FIFO_DEPTH_SHORT;
    e.ja_latency = e.fifo_depth >> 1;
    e.send_qrss = (sh_t[c][6:4] == 3'h4);
    e.send_all_ones = (sh_t[c][6:4] == 3'h5);
    e.qrss_invert = sh_t[c][7];
    e.tx_powered = tx_power_pin_control ? tx_enable_pin[c] : sh_t[c][3];
    e.loop_dual = (sh_t[c][2:0] == 3'h4);
    e.loop_analog = (sh_t[c][2:0] == 3'h5);
    e.loop_remote = (sh_t[c][2:0] == 3'h6);
    e.loop_digital = (sh_t[c][2:0] == 3'h7);
    e.coding_ami = sh_c[c][5];
    return e;
  endfunction

  // Compare every channel against its shadow
  task automatic chk_ctl();
    for (int c = 0; c < 8; c++) begin
      chk("chan_ctl", 32'(exp_ctl(c)), 32'(chan_ctl[c]));
    end
  endtask

  // Register write, one strobe cycle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    host_req.wr <= 1'b1;
    host_req.addr <= a;
    host_req.wdata <= d;
    @(posedge ref_clk);
    host_req.wr <= 1'b0;
  endtask

  // Register read, valid expected one cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    host_req.rd <= 1'b1;
    host_req.addr <= a;
    @(posedge ref_clk);
    host_req.rd <= 1'b0;
    #1;
    chk("host_rd_valid", 32'h1, 32'(host_rd_valid));
    chk("host_rdata", 32'(e), 32'(host_rdata));
    @(posedge ref_clk);
    #1;
    chk("host_rd_valid_drop", 32'h0, 32'(host_rd_valid));
  endtask

  // Reset pulse, outputs cleared at once, defaults after release
  task automatic do_reset();
    @(posedge ref_clk);
    resetn <= 1'b0;
    #1;
    chk("rd_valid_in_reset", 32'h0, 32'(host_rd_valid));
    for (int c = 0; c < 8; c++) begin
      chk("ctl_in_reset", 32'h0, 32'(chan_ctl[c]));
    end
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      sh_j[c] = 8'h00;
      sh_t[c] = 8'h00;
      sh_c[c] = 8'h00;
    end
    repeat (4) @(posedge ref_clk);
    #1;
    chk_ctl();
    for (int c = 0; c < 8; c++) begin
      for (int o = 1; o < 4; o++) begin
        rd_chk({c[3:0], o[3:0]}, 8'h00);
      end
    end
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    logic [7:0] a;
    resetn = 1'b0;
    host_req = '0;
    tx_power_pin_control = 1'b0;
    tx_enable_pin = 8'h00;
    fail_count = 0;
    checked = 0;
    do_reset();
    // Table of writes, read back and decoded outputs
    for (int r = 0; r < 20; r++) begin
      a = rows[r][23:16];
      wr_reg(a, rows[r][15:8]);
      if (a[7:4] < 4'h8) begin
        case (a[3:0])
          4'h1: sh_j[a[7:4]] = rows[r][15:8];
          4'h2: sh_t[a[7:4]] = rows[r][15:8];
          4'h3: sh_c[a[7:4]] = rows[r][15:8];
          default: ;
        endcase
      end
      rd_chk(a, rows[r][7:0]);
      chk_ctl();
    end
    // Pin control hands transmitter power to the enable pins
    @(posedge ref_clk);
    tx_power_pin_control <= 1'b1;
    tx_enable_pin <= 8'hA5;
    repeat (8) @(posedge ref_clk);
    #1;
    chk_ctl();
    @(posedge ref_clk);
    tx_enable_pin <= 8'h5A;
    repeat (8) @(posedge ref_clk);
    #1;
    chk_ctl();
    @(posedge ref_clk);
    tx_power_pin_control <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    chk_ctl();
    // Write then read on the next cycle, then write and read together
    @(posedge ref_clk);
    host_req.wr <= 1'b1;
    host_req.addr <= 8'h32;
    host_req.wdata <= 8'hC8;
    @(posedge ref_clk);
    host_req.wr <= 1'b0;
    host_req.rd <= 1'b1;
    @(posedge ref_clk);
    host_req.wr <= 1'b1;
    host_req.wdata <= 8'h15;
    #1;
    chk("rdata_after_write", 32'hC8, 32'(host_rdata));
    chk("rd_valid_after_write", 32'h1, 32'(host_rd_valid));
    @(posedge ref_clk);
    host_req.wr <= 1'b0;
    host_req.rd <= 1'b0;
    #1;
    chk("rdata_read_with_write", 32'hC8, 32'(host_rdata));
    sh_t[3] = 8'h15;
    rd_chk(8'h32, 8'h15);
    chk_ctl();
    // Reset in mid-run with registers loaded
    do_reset();
    end_sim();
  end
endmodule
